// ===== core/rfct_trigger.v
// receive flow-control trigger: back pressure and pause requests
// assumes fifo level and frame-class strobes are synchronous to sys_clk
// and that the mac builds and queues the pause frames it is asked for
// limitation: the low threshold is trusted to sit below the high one;
// a bad pair makes pause and resume frames alternate while the fill sits between the two
// the status word is read only and shows the live fill in units
//
// How it works
// - jam lasts the programmed duration code
// - duration code unused in full duplex
// - multicast frame triggers jam above threshold
// - broadcast frame triggers jam above threshold
// - own-address frame triggers jam above threshold
// - any-frame bit alone enables full-duplex control
// - half duplex any-frame acts on preamble
// - full duplex requests pause at threshold
// - any-frame bit overrides the other triggers
// - 100 Mb/s durations 5 to 600 us
// - 10 Mb/s adds 2.2 us
// - high threshold in 64-byte units, one pause
// - zero pause below low after pause
// - nothing while transmitter is disabled
// - half duplex jams each matching frame
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "rfct_consts.vh"

module rfct_trigger #(
    parameter CYCLES_PER_TENTH = `RFCT_CYC_PER_TENTH
) (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [13:0] rxFifoLevel,
    input wire fullDuplex,
    input wire linkSpeed100,
    input wire txEnable,
    input wire rxPreamble,
    input wire rxFrameDecoded,
    input wire rxIsMulticast,
    input wire rxIsBroadcast,
    input wire rxIsOwnAddress,
    output reg jamActive,
    output reg pauseRequest,
    output reg pauseZeroRequest
);

    // ------------------------------------------------------------
    // duration lookup
    // ------------------------------------------------------------
    // 100 Mb/s column
    // 100 Mb/s duration in tenths of a microsecond
    function [12:0] durTenths;
        input [3:0] code;
        begin
            case (code)
                4'h0: durTenths = 13'd50;
                4'h1: durTenths = 13'd100;
                4'h2: durTenths = 13'd150;
                4'h3: durTenths = 13'd250;
                4'h4: durTenths = 13'd500;
                4'h5: durTenths = 13'd1000;
                4'h6: durTenths = 13'd1500;
                4'h7: durTenths = 13'd2000;
                4'h8: durTenths = 13'd2500;
                4'h9: durTenths = 13'd3000;
                4'ha: durTenths = 13'd3500;
                4'hb: durTenths = 13'd4000;
                4'hc: durTenths = 13'd4500;
                4'hd: durTenths = 13'd5000;
                4'he: durTenths = 13'd5500;
                default: durTenths = 13'd6000;
            endcase
        end
    endfunction

    // address decode used by both the read mux and write path
    function isCfg;
        input [7:0] a;
        begin
            isCfg = (a == `RFCT_CFG_ADDR);
        end
    endfunction

    function isStat;
        input [7:0] a;
        begin
            isStat = (a == `RFCT_STAT_ADDR);
        end
    endfunction

    // ------------------------------------------------------------
    // state machine codes (one-hot)
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_JAM = 3'b010;
    localparam [2:0] ST_PAUSED = 3'b100;

    // 17 bits hold 6022 tenths at 20 cycles each
    localparam [16:0] CYC_TENTH = CYCLES_PER_TENTH[16:0];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [31:0] cfg_q;
    reg [31:0] cfg_d;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [16:0] timer_q;
    reg [16:0] timer_d;
    reg pauseReq_d;
    reg pauseZero_d;
    reg accessDone;
    reg [31:0] rdMux;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    wire [7:0] hiLevel = cfg_q[`RFCT_HI_MSB:`RFCT_HI_LSB];
    wire [7:0] loLevel = cfg_q[`RFCT_LO_MSB:`RFCT_LO_LSB];
    wire [3:0] durCode = cfg_q[`RFCT_DUR_MSB:`RFCT_DUR_LSB];
    wire trigMcast = cfg_q[`RFCT_MCAST_BIT];
    wire trigBcast = cfg_q[`RFCT_BCAST_BIT];
    wire trigOwn = cfg_q[`RFCT_OWN_BIT];
    wire trigAny = cfg_q[`RFCT_ANY_BIT];

    // ------------------------------------------------------------
    // state decode
    // ------------------------------------------------------------
    wire inJam = (state_q == ST_JAM);
    wire inPaused = (state_q == ST_PAUSED);

    // ------------------------------------------------------------
    // fill level compare
    // ------------------------------------------------------------
    // 64-byte units
    wire [7:0] levelUnits = rxFifoLevel[13:`RFCT_UNIT_SHIFT];
    // a partly filled unit does not count toward a threshold
    wire atHigh = (levelUnits >= hiLevel);
    // low threshold assumed below high by software, not checked here
    wire belowLow = (levelUnits < loLevel);

    // ------------------------------------------------------------
    // half-duplex trigger selection
    // ------------------------------------------------------------
    // multicast class
    wire mcastHit = trigMcast & rxIsMulticast;
    wire bcastHit = trigBcast & rxIsBroadcast;
    wire ownHit = trigOwn & rxIsOwnAddress;
    // class bits are only valid with the decode strobe
    wire classHit = rxFrameDecoded & (mcastHit | bcastHit | ownHit);

    wire anyHit = rxPreamble;
    wire hdFire = txEnable & ~fullDuplex & atHigh
                & (trigAny ? anyHit : classHit);

    // ------------------------------------------------------------
    // full-duplex trigger
    // ------------------------------------------------------------
    // only the any-frame bit counts
    wire fdFire = txEnable & fullDuplex & trigAny & atHigh;

    // ------------------------------------------------------------
    // duration to cycles
    // ------------------------------------------------------------
    // slow link adds 2.2 us
    wire [12:0] tenths = durTenths(durCode)
                       + (linkSpeed100 ? 13'd0 : `RFCT_SLOW_EXTRA_TENTHS);
    wire [29:0] prod = tenths * CYC_TENTH;
    wire [16:0] jamCycles = prod[16:0];
    // a code change mid-jam only affects the next reload
    wire timerLast = (timer_q <= 17'h00001);

    // ------------------------------------------------------------
    // flow-control state machine
    // ------------------------------------------------------------
    // full duplex paused state survives jam timing so a
    // duplex change mid-jam simply drops the jam
    always @* begin
        state_d = state_q;
        timer_d = timer_q;
        pauseReq_d = 1'b0;
        pauseZero_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // fdFire and hdFire never hold together
                if (fdFire) begin
                    pauseReq_d = 1'b1;
                    state_d = ST_PAUSED;
                end else if (hdFire) begin
                    timer_d = jamCycles;
                    state_d = ST_JAM;
                end
            end
            ST_JAM: begin
                if (~txEnable | fullDuplex) begin
                    timer_d = 17'h00000;
                    state_d = ST_IDLE;
                end else if (hdFire) begin
                    // each matching frame re-jams
                    // reload, not extend: the newest frame gets the full time
                    timer_d = jamCycles;
                end else if (timerLast) begin
                    timer_d = 17'h00000;
                    state_d = ST_IDLE;
                end else begin
                    timer_d = timer_q - 17'h00001;
                end
            end
            ST_PAUSED: begin
                // with the transmitter off the owed resume waits
                // zero pause after a pause
                if (belowLow & txEnable) begin
                    pauseZero_d = 1'b1;
                    state_d = ST_IDLE;
                end else if (~fullDuplex | ~trigAny) begin
                    // control withdrawn: no resume frame owed
                    state_d = ST_IDLE;
                end
            end
            default: begin
                // an illegal one-hot code falls back to idle
                timer_d = 17'h00000;
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            timer_q <= 17'h00000;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // silent while transmitter off
    wire jamNext = (state_d == ST_JAM) & txEnable;
    wire pauseNext = pauseReq_d & txEnable;
    wire zeroNext = pauseZero_d & txEnable;

    // taken from the next state so a jam starts one edge after its trigger
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            jamActive <= 1'b0;
            pauseRequest <= 1'b0;
            pauseZeroRequest <= 1'b0;
        end else begin
            jamActive <= jamNext;
            pauseRequest <= pauseNext;
            pauseZeroRequest <= zeroNext;
        end
    end

    // ------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------
    // the wait state lets pready be a plain flop, at one cycle a transfer
    wire cfgSel = isCfg(paddr);
    wire statSel = isStat(paddr);
    wire firstAccess = psel & penable & ~pready;
    wire badAccess = ~(cfgSel | (statSel & ~pwrite));
    // a refused write leaves every byte as it was
    wire cfgWrite = accessDone & pwrite & cfgSel;
    wire [31:0] cfgMerged;

    // one lane per byte strobe
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gLane
            assign cfgMerged[g*8 +: 8] = (cfgWrite & pstrb[g]) ? pwdata[g*8 +: 8]
                                       : cfg_q[g*8 +: 8];
        end
    endgenerate

    // the reserved top byte never holds a one
    always @* begin
        accessDone = psel & penable & pready;
        cfg_d = cfgMerged & `RFCT_CFG_MASK;
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @* begin
        rdMux = 32'h00000000;
        if (cfgSel) begin
            rdMux = cfg_q;
        end else if (statSel) begin
            rdMux[`RFCT_ST_JAM_BIT] = inJam;
            rdMux[`RFCT_ST_PAUSED_BIT] = inPaused;
            rdMux[`RFCT_ST_ABOVE_BIT] = atHigh;
            rdMux[`RFCT_ST_LOW_BIT] = belowLow;
            rdMux[`RFCT_ST_LVL_LSB +: 8] = levelUnits;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cfg_q <= `RFCT_CFG_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            cfg_q <= cfg_d;
            pready <= firstAccess;
            // error and data answer together with pready
            if (firstAccess) begin
                pslverr <= badAccess;
                prdata <= pwrite ? 32'h00000000 : rdMux;
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

endmodule

// ===== core/rfct_consts.vh
// constants for the receive flow-control trigger block
// assumes a 200 MHz system clock and an APB register port
`ifndef RFCT_CONSTS_VH
`define RFCT_CONSTS_VH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define RFCT_ADDR_W 8
`define RFCT_CFG_ADDR 8'hac
`define RFCT_STAT_ADDR 8'hc0
`define RFCT_CFG_RESET 32'h00000000
`define RFCT_CFG_MASK 32'h00ffffff

// ------------------------------------------------------------
// config field positions
// ------------------------------------------------------------
`define RFCT_HI_MSB 23
`define RFCT_HI_LSB 16
`define RFCT_LO_MSB 15
`define RFCT_LO_LSB 8
`define RFCT_DUR_MSB 7
`define RFCT_DUR_LSB 4
`define RFCT_MCAST_BIT 3
`define RFCT_BCAST_BIT 2
`define RFCT_OWN_BIT 1
`define RFCT_ANY_BIT 0

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define RFCT_ST_JAM_BIT 0
`define RFCT_ST_PAUSED_BIT 1
`define RFCT_ST_ABOVE_BIT 2
`define RFCT_ST_LOW_BIT 3
`define RFCT_ST_LVL_LSB 8

// ------------------------------------------------------------
// fifo level: bytes, threshold unit is 64 bytes
// ------------------------------------------------------------
`define RFCT_LVL_W 14
`define RFCT_UNIT_SHIFT 6

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RFCT_CLK_PS 5000
`define RFCT_TENTH_US_PS 100000
`define RFCT_CYC_PER_TENTH (`RFCT_TENTH_US_PS / `RFCT_CLK_PS)
`define RFCT_SLOW_EXTRA_TENTHS 13'd22
`define RFCT_TIMER_W 17

`endif

// ===== tb/rfct_monitor.sv
// checker for the flow-control trigger ports
// assumes binding onto rfct_trigger, one clock, sync active-low reset
`timescale 1ns/10ps
module rfct_monitor (
    input wire sys_clk, rst_n, psel, penable, pready, pslverr,
    input wire fullDuplex, txEnable, rxPreamble, rxFrameDecoded,
    input wire jamActive, pauseRequest, pauseZeroRequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("apb wait state wrong");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_TX_OFF: assert property (!$past(txEnable) |->
        !(jamActive || pauseRequest || pauseZeroRequest)) else $error("output with tx off");
    AST_FD_NO_JAM: assert property ($past(fullDuplex) |-> !jamActive)
        else $error("jam in full duplex");
    AST_PAUSE_FD: assert property (pauseRequest |-> $past(fullDuplex && txEnable))
        else $error("pause outside full duplex");
    AST_PAUSE_PULSE: assert property (pauseRequest |=> !pauseRequest)
        else $error("pause request not a pulse");
    AST_ZERO_PULSE: assert property (pauseZeroRequest |=> !pauseZeroRequest)
        else $error("zero pause not a pulse");
    AST_JAM_CAUSE: assert property ($rose(jamActive) |->
        $past(rxPreamble || rxFrameDecoded)) else $error("jam without frame");
    cover property ($rose(jamActive));
    cover property (pauseRequest);
    cover property (pauseZeroRequest);
endmodule
bind rfct_trigger rfct_monitor i_rfct_monitor (.*);

// ===== tb/rfct_link_partner.sv
// remote link partner: frame start and address-decode strobes
// assumes go is a one-cycle request from the bench
`timescale 1ns/10ps
module rfct_link_partner (
    input wire sys_clk,
    input wire go,
    input wire [2:0] cls,
    output reg rxPreamble = 1'b0,
    output reg rxFrameDecoded = 1'b0,
    output reg [2:0] clsOut = 3'h0
);
    reg [3:0] cnt_q = 4'h0;
    always @(posedge sys_clk) begin
        rxPreamble <= go;
        rxFrameDecoded <= cnt_q == 4'h1;
        // class is scrambled outside the decode strobe so nothing stale leaks
        clsOut <= (cnt_q == 4'h1) ? cls : ~clsOut;
        cnt_q <= (cnt_q != 4'h0) ? cnt_q - 4'h1 : (go ? 4'h8 : 4'h0);
    end
endmodule

// ===== tb/tb_rfct_trigger.sv
// bench for rfct_trigger: apb config, jam lengths, pause requests
// assumes the design runs with one cycle per tenth of a microsecond
`timescale 1ns/10ps
`include "rfct_consts.vh"
module tb_rfct_trigger;
    localparam int CPT = 1;
    // status after the pause: level 3 units, above high, paused
    localparam logic [31:0] STAT_EXP = (32'd3 << `RFCT_ST_LVL_LSB)
        | (32'd1 << `RFCT_ST_ABOVE_BIT) | (32'd1 << `RFCT_ST_PAUSED_BIT);
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h3548e5ef;
    logic [3:0] pstrb = 4'hf;
    logic [13:0] rxFifoLevel = 14'h0;
    logic fullDuplex = 1'b0, linkSpeed100 = 1'b1, txEnable = 1'b0, go = 1'b0, err;
    logic [2:0] cls = 3'h0, klass;
    logic pready, pslverr, rxPreamble, rxFrameDecoded, jamActive, pauseRequest, pauseZeroRequest;
    int mismatches = 0, comparisons = 0, nPause = 0, nZero = 0, n;
    rfct_trigger #(.CYCLES_PER_TENTH(CPT)) i_rfct_trigger (.*, .rxIsMulticast(klass[2]),
        .rxIsBroadcast(klass[1]), .rxIsOwnAddress(klass[0]));
    rfct_link_partner i_rfct_link_partner (.*, .clsOut(klass));
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (pauseRequest === 1'b1) nPause++;
        if (pauseZeroRequest === 1'b1) nZero++;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int jamCycles(input logic [3:0] c, input logic fast);
        int t;
        t = c < 3 ? 50 * (c + 1) : (c < 5 ? 250 * (c - 2) : 500 * (c - 3));
        return (t + (fast ? 0 : 22)) * CPT;
    endfunction
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic jam(input logic [2:0] c, input int exp);
        @(posedge sys_clk);
        go <= 1'b1;
        cls <= c;
        @(posedge sys_clk);
        go <= 1'b0;
        for (n = 0; jamActive !== 1'b1 && n < 20; n++) @(posedge sys_clk);
        for (n = 0; jamActive === 1'b1 && n < 7000; n++) @(posedge sys_clk);
        chk(n == exp, "jam length");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #450000;
        mismatches++;
        results();
    end
    initial begin
        logic [31:0] v, old;
        repeat (20) @(posedge sys_clk);
        {rst_n, txEnable} <= 2'b11;
        apb(0, `RFCT_CFG_ADDR, 0, 4'hf);
        chk(rd === `RFCT_CFG_RESET && err === 1'b0, "cfg reset");
        for (int i = 0; i < 6; i++) begin
            v = xs();
            old = rd;
            apb(1, `RFCT_CFG_ADDR, v, v[31:28]);
            for (int b = 0; b < 4; b++) if (v[28 + b]) old[8 * b +: 8] = v[8 * b +: 8];
            apb(0, `RFCT_CFG_ADDR, 0, 4'hf);
            chk(rd === (old & `RFCT_CFG_MASK), "cfg readback");
        end
        apb(0, 8'h10, 0, 4'hf);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1, `RFCT_STAT_ADDR, 32'hffffffff, 4'hf);
        chk(err === 1'b1, "status write");
        rxFifoLevel <= 14'd64;
        for (int c = 0; c < 16; c++) begin
            apb(1, `RFCT_CFG_ADDR, {16'h0001, 8'h00, c[3:0], 4'h1 << (c % 4)}, 4'hf);
            jam(c % 4 ? 3'h1 << (c % 4 - 1) : 3'h0, jamCycles(c, 1));
        end
        jam(3'h3, 0);
        apb(1, `RFCT_CFG_ADDR, 32'h0001_000f, 4'hf);
        jam(3'h0, jamCycles(0, 1));
        rxFifoLevel <= 14'd63;
        jam(3'h7, 0);
        linkSpeed100 <= 1'b0;
        rxFifoLevel <= 14'd64;
        for (int i = 0; i < 3; i++) begin
            v = xs();
            apb(1, `RFCT_CFG_ADDR, {16'h0001, 8'h00, v[3:0], 4'h2}, 4'hf);
            jam(3'h1, jamCycles(v[3:0], 0));
        end
        {fullDuplex, rxFifoLevel} <= {1'b1, 14'd200};
        apb(1, `RFCT_CFG_ADDR, 32'h0002_01fe, 4'hf);
        jam(3'h7, 0);
        chk(nPause == 0, "pause without any-frame bit");
        rxFifoLevel <= 14'd0;
        apb(1, `RFCT_CFG_ADDR, 32'h0002_01f1, 4'hf);
        rxFifoLevel <= 14'd200;
        repeat (4) @(posedge sys_clk);
        chk(nPause == 1, "pause at high level");
        apb(0, `RFCT_STAT_ADDR, 0, 4'hf);
        chk(rd === STAT_EXP && err === 1'b0, "status after pause");
        jam(3'h7, 0);
        rxFifoLevel <= 14'd100;
        repeat (4) @(posedge sys_clk);
        chk(nPause == 1 && nZero == 0, "single pause, no early resume");
        rxFifoLevel <= 14'd10;
        repeat (4) @(posedge sys_clk);
        chk(nZero == 1, "zero pause below low");
        {txEnable, rxFifoLevel} <= {1'b0, 14'd200};
        repeat (4) @(posedge sys_clk);
        chk(nPause == 1, "pause with tx off");
        results();
    end
endmodule
